// *** csi_chan.sv ***
// level classifier of one input channel
`timescale 1ns/100ps
`include "csi_defines.svh"

module csi_chan
  import csi_pkg::*;
(
  input  wire logic          full_sel,
  input  wire csi_pkg::csi_rms_t half_rms,
  input  wire csi_pkg::csi_rms_t full_rms,
  input  wire logic          is_current,
  input  wire csi_pkg::csi_rms_t lim_lo,
  input  wire csi_pkg::csi_rms_t lim_hi,
  input  wire csi_pkg::csi_rms_t cur_range,
  input  wire logic          range_auto,
  input  wire logic          adc_ovf,
  output logic               under,
  output logic               over,
  output logic               ovf
);

  wire csi_rms_t   rms       = full_sel ? full_rms : half_rms;
  wire logic [19:0] rms_x10  = 20'(rms) * 20'(`CSI_UNDER_DIV);
  wire logic       cur_under = ~range_auto & (rms_x10 < 20'(cur_range));
  wire logic       volt_under = rms < lim_lo;

  assign ovf   = adc_ovf;
  assign under = ~adc_ovf & (is_current ? cur_under : volt_under);
  assign over  = ~adc_ovf & ~is_current & (rms > lim_hi);

endmodule : csi_chan

// *** csi_defines.svh ***
// register offsets, field positions, reset values and timing counts of the indicator block
`ifndef CSI_DEFINES_SVH
`define CSI_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CSI_OFF_CTRL      8'h00
`define CSI_OFF_SERCFG    8'h04
`define CSI_OFF_LIM_LO    8'h08
`define CSI_OFF_LIM_HI    8'h0c
`define CSI_OFF_RANGE     8'h10
`define CSI_OFF_CHTYPE    8'h14
`define CSI_OFF_NEG_THR   8'h18
`define CSI_OFF_STATUS    8'h1c
`define CSI_OFF_MASK      8'h20
`define CSI_OFF_STATE     8'h24

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CSI_CTRL_FULL_BIT   0
`define CSI_RANGE_AUTO_BIT  16
`define CSI_SER_BAUD_LSB    0
`define CSI_SER_BAUD_MSB    19
`define CSI_SER_DATA_LSB    20
`define CSI_SER_DATA_MSB    23
`define CSI_SER_STOP_BIT    24
`define CSI_SER_PAR_LSB     25
`define CSI_SER_PAR_MSB     26
`define CSI_ST_PHASE_BIT    0
`define CSI_ST_COPYERR_BIT  1
`define CSI_ST_CARD_BIT     2
`define CSI_ST_ALARM_BIT    3
`define CSI_ST_OVF_BIT      4
`define CSI_ST_ERASE_BIT    5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CSI_RST_SER_BAUD    20'h0e100
`define CSI_RST_SER_DATA    4'h8
`define CSI_RST_SER_STOP    1'h0
`define CSI_RST_SER_PAR     2'h0
`define CSI_RST_LIM_LO      16'h0000
`define CSI_RST_LIM_HI      16'hffff
`define CSI_RST_RANGE       17'h10000
`define CSI_RST_NEG_THR     16'hffff

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CSI_CLK_HZ          200000000
`define CSI_MS_PER_S        1000
`define CSI_CYC_PER_MS      (`CSI_CLK_HZ / 1000)
`define CSI_SLOW_MS         1000
`define CSI_NORM_MS         500
`define CSI_FAST_MS         125
`define CSI_ERR_FLASH_S     3
`define CSI_ERR_FLASH_MS    (`CSI_ERR_FLASH_S * `CSI_MS_PER_S)
`define CSI_DBL_ON_MS       100
`define CSI_UNDER_DIV       10

`endif

// *** csi_front_model.sv ***
// measurement front end and alarm wiring model
`timescale 1ns/100ps
module csi_front_model (
  input  wire logic         aclk,
  input  wire logic [15:0]  lvl,
  input  wire logic [7:0]   ovf,
  input  wire logic         go,
  input  wire logic [1:0]   clr,
  output logic              rms_strobe,
  output logic [127:0]      half_rms,
  output logic [127:0]      full_rms,
  output logic [7:0]        adc_ovf,
  output logic              alarm_clear_a,
  output logic              alarm_clear_b
);
  // full-cycle value is half, so the selections classify apart
  always @(posedge aclk) begin
    rms_strobe    <= go;
    half_rms      <= {8{lvl}};
    full_rms      <= {8{1'h0, lvl[15:1]}};
    adc_ovf       <= ovf;
    alarm_clear_a <= clr[0];
    alarm_clear_b <= clr[1];
  end
endmodule : csi_front_model

// *** csi_pkg.sv ***
// types shared by the indicator block
package csi_pkg;

  typedef enum logic [2:0] {
    CSI_ST_IDLE,
    CSI_ST_GREET,
    CSI_ST_COPY,
    CSI_ST_ERR,
    CSI_ST_HOLD
  } csi_store_t;

  typedef logic [15:0] csi_rms_t;

endpackage : csi_pkg

// *** csi_top.sv ***
// channel, storage and alarm indicator logic with its register slave
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "csi_defines.svh"

// What this block does
// - three LEDs per channel, half/full rms
// - sensor ok: ok green, dip/swell yellow
// - no sensor: ok LED red, others unchanged
// - voltage limits equal dip/swell thresholds
// - current under below tenth of range, off with range_auto set (reset default)
// - converter overflow flashes over LED red
// - wrong phase order chases the first three ok LEDs
// - copy flashes, done off, incomplete on
// - copy error: fast flash 3 s, on
// - card recognised: short double pulses
// - serial port defaults 57600 8N1
// - alarms latch until their clear input
// - reset button at boot erases data
module csi_top
  import csi_pkg::*;
#(
  parameter int CYC_PER_MS = `CSI_CYC_PER_MS
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         rms_strobe,
  input  wire logic [127:0] half_rms,
  input  wire logic [127:0] full_rms,
  input  wire logic [7:0]   sensor_ok,
  input  wire logic [7:0]   adc_ovf,
  input  wire logic [15:0]  neg_seq,
  input  wire logic         card_detect,
  input  wire logic         copy_start,
  input  wire logic         copy_done,
  input  wire logic         copy_incomplete,
  input  wire logic         copy_error,
  input  wire logic [3:0]   alarm_event,
  input  wire logic         alarm_clear_a,
  input  wire logic         alarm_clear_b,
  input  wire logic         reset_button,
  input  wire logic         erase_done,
  output logic [7:0]        led_under_yellow,
  output logic [7:0]        led_ok_green,
  output logic [7:0]        led_ok_red,
  output logic [7:0]        led_over_yellow,
  output logic [7:0]        led_over_red,
  output logic              led_storage,
  output logic              alarm_out_first,
  output logic              alarm_out_second,
  output logic              alarm_out_third,
  output logic              alarm_out_fourth,
  output logic              erase_data,
  output logic [19:0]       ser_baud,
  output logic [3:0]        ser_data_bits,
  output logic              ser_two_stop,
  output logic [1:0]        ser_parity,
  output logic              irq
);

  import csi_pkg::*;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic        full_sel;
  logic [15:0] lim_lo;
  logic [15:0] lim_hi;
  logic [16:0] range_cfg;
  logic [7:0]  is_current;
  logic [15:0] neg_thr;
  logic [5:0]  status;
  logic [5:0]  mask;

  // --------------------------------------------------------------------------
  // axi4-lite slave: address and data latched in either order
  // --------------------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_full;
  logic        w_full;

  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take  = s_axi_wvalid & s_axi_wready;
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic do_wr   = ce & aw_full & w_full & ~s_axi_bvalid;
  wire logic wr_word = do_wr & (w_strb == 4'hf);
  wire logic wr_hit = (aw_addr <= `CSI_OFF_STATUS + 8'h04) & (aw_addr[1:0] == 2'h0) & (aw_addr != `CSI_OFF_STATE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= ~aw_full & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_full & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire logic wr_ctrl   = wr_word & (aw_addr == `CSI_OFF_CTRL);
  wire logic wr_ser    = wr_word & (aw_addr == `CSI_OFF_SERCFG);
  wire logic wr_lo     = wr_word & (aw_addr == `CSI_OFF_LIM_LO);
  wire logic wr_hi     = wr_word & (aw_addr == `CSI_OFF_LIM_HI);
  wire logic wr_range  = wr_word & (aw_addr == `CSI_OFF_RANGE);
  wire logic wr_type   = wr_word & (aw_addr == `CSI_OFF_CHTYPE);
  wire logic wr_thr    = wr_word & (aw_addr == `CSI_OFF_NEG_THR);
  wire logic wr_status = wr_word & (aw_addr == `CSI_OFF_STATUS);
  wire logic wr_mask   = wr_word & (aw_addr == `CSI_OFF_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_sel      <= 1'b0;
      lim_lo        <= `CSI_RST_LIM_LO;
      lim_hi        <= `CSI_RST_LIM_HI;
      range_cfg     <= `CSI_RST_RANGE;
      is_current    <= 8'h00;
      neg_thr       <= `CSI_RST_NEG_THR;
      mask          <= 6'h00;
      ser_baud      <= `CSI_RST_SER_BAUD;
      ser_data_bits <= `CSI_RST_SER_DATA;
      ser_two_stop  <= `CSI_RST_SER_STOP;
      ser_parity    <= `CSI_RST_SER_PAR;
    end else if (ce) begin
      if (wr_ctrl) full_sel <= w_data[`CSI_CTRL_FULL_BIT];
      if (wr_lo) lim_lo <= w_data[15:0];
      if (wr_hi) lim_hi <= w_data[15:0];
      if (wr_range) range_cfg <= w_data[16:0];
      if (wr_type) is_current <= w_data[7:0];
      if (wr_thr) neg_thr <= w_data[15:0];
      if (wr_mask) mask <= w_data[5:0];
      if (wr_ser) begin
        ser_baud      <= w_data[`CSI_SER_BAUD_MSB:`CSI_SER_BAUD_LSB];
        ser_data_bits <= w_data[`CSI_SER_DATA_MSB:`CSI_SER_DATA_LSB];
        ser_two_stop  <= w_data[`CSI_SER_STOP_BIT];
        ser_parity    <= w_data[`CSI_SER_PAR_MSB:`CSI_SER_PAR_LSB];
      end
    end
  end

  // --------------------------------------------------------------------------
  // flash rate generation
  // --------------------------------------------------------------------------
  logic [17:0] pre_cnt;
  logic [9:0]  ms_cnt;
  logic [6:0]  fast_cnt;
  logic [11:0] err_cnt;

  wire logic ms_tick    = (pre_cnt == 18'(CYC_PER_MS - 1));
  wire logic ms_wrap    = ms_tick & (ms_cnt == 10'(`CSI_SLOW_MS - 1));
  wire logic flash_slow = (ms_cnt < 10'(`CSI_SLOW_MS / 2));
  wire logic flash_norm = (ms_cnt < 10'(`CSI_NORM_MS / 2)) |
                          ((ms_cnt >= 10'(`CSI_NORM_MS)) & (ms_cnt < 10'(`CSI_NORM_MS * 3 / 2)));
  wire logic flash_fast = (fast_cnt < 7'(`CSI_FAST_MS / 2));
  wire logic dbl_pulse  = (ms_cnt < 10'(`CSI_DBL_ON_MS)) |
                          ((ms_cnt >= 10'(2 * `CSI_DBL_ON_MS)) & (ms_cnt < 10'(3 * `CSI_DBL_ON_MS)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt  <= 18'h00000;
      ms_cnt   <= 10'h000;
      fast_cnt <= 7'h00;
    end else if (ce) begin
      pre_cnt <= ms_tick ? 18'h00000 : pre_cnt + 18'h00001;
      if (ms_tick) begin
        ms_cnt   <= ms_wrap ? 10'h000 : ms_cnt + 10'h001;
        fast_cnt <= (fast_cnt == 7'(`CSI_FAST_MS - 1) || ms_wrap) ? 7'h00 : fast_cnt + 7'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // channel classification
  // --------------------------------------------------------------------------
  logic [7:0] cls_under;
  logic [7:0] cls_over;
  logic [7:0] cls_ovf;
  logic [7:0] under_q;
  logic [7:0] over_q;
  logic [7:0] ovf_q;
  logic       phase_bad;
  logic [1:0] chase;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_chan
      csi_chan u_chan (
        .full_sel   (full_sel),
        .half_rms   (half_rms[16*g +: 16]),
        .full_rms   (full_rms[16*g +: 16]),
        .is_current (is_current[g]),
        .lim_lo     (lim_lo),
        .lim_hi     (lim_hi),
        .cur_range  (range_cfg[15:0]),
        .range_auto (range_cfg[`CSI_RANGE_AUTO_BIT]),
        .adc_ovf    (adc_ovf[g]),
        .under      (cls_under[g]),
        .over       (cls_over[g]),
        .ovf        (cls_ovf[g])
      );
    end
  endgenerate

  // chase steps third, second, first phase once per normal flash period
  wire logic       chase_step = ms_tick & ((ms_cnt == 10'(`CSI_NORM_MS - 1)) | (ms_cnt == 10'(`CSI_SLOW_MS - 1)));
  wire logic [7:0] chase_led  = (chase == 2'h0) ? 8'h04 : (chase == 2'h1) ? 8'h02 : 8'h01;
  wire logic [7:0] phase_mask = phase_bad ? 8'h07 : 8'h00;
  wire logic [7:0] ok_plain   = sensor_ok & ~under_q & ~over_q & ~ovf_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      under_q   <= 8'h00;
      over_q    <= 8'h00;
      ovf_q     <= 8'h00;
      phase_bad <= 1'b0;
      chase     <= 2'h0;
    end else if (ce) begin
      if (rms_strobe) begin
        under_q   <= cls_under;
        over_q    <= cls_over;
        ovf_q     <= cls_ovf;
        phase_bad <= neg_seq > neg_thr;
      end
      if (chase_step) chase <= (chase == 2'h2) ? 2'h0 : chase + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_under_yellow <= 8'h00;
      led_ok_green     <= 8'h00;
      led_ok_red       <= 8'h00;
      led_over_yellow  <= 8'h00;
      led_over_red     <= 8'h00;
    end else if (ce) begin
      led_under_yellow <= under_q;
      led_over_yellow  <= over_q;
      led_over_red     <= ovf_q & {8{flash_norm}};
      led_ok_red       <= ~sensor_ok;
      led_ok_green     <= (ok_plain & ~phase_mask) | (chase_led & phase_mask & sensor_ok);
    end
  end

  // --------------------------------------------------------------------------
  // storage LED sequencer
  // --------------------------------------------------------------------------
  csi_store_t store_st;
  csi_store_t next_store_st;

  // removal is safe only in idle or hold, where the LED is steady
  always_comb begin
    next_store_st = store_st;
    unique case (store_st)
      CSI_ST_IDLE, CSI_ST_HOLD: begin
        if (copy_start) next_store_st = CSI_ST_COPY;
        else if (card_detect) next_store_st = CSI_ST_GREET;
      end
      CSI_ST_GREET: begin
        if (copy_start) next_store_st = CSI_ST_COPY;
        else if (ms_wrap) next_store_st = CSI_ST_IDLE;
      end
      CSI_ST_COPY: begin
        if (copy_error) next_store_st = CSI_ST_ERR;
        else if (copy_incomplete) next_store_st = CSI_ST_HOLD;
        else if (copy_done) next_store_st = CSI_ST_IDLE;
      end
      CSI_ST_ERR: begin
        if (ms_tick && err_cnt == 12'(`CSI_ERR_FLASH_MS - 1)) next_store_st = CSI_ST_HOLD;
      end
      default: next_store_st = CSI_ST_IDLE;
    endcase
  end

  wire logic store_led = (store_st == CSI_ST_HOLD) |
                         ((store_st == CSI_ST_COPY) & flash_norm) |
                         ((store_st == CSI_ST_ERR) & flash_fast) |
                         ((store_st == CSI_ST_GREET) & dbl_pulse);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_st    <= CSI_ST_IDLE;
      err_cnt     <= 12'h000;
      led_storage <= 1'b0;
    end else if (ce) begin
      store_st    <= next_store_st;
      led_storage <= store_led;
      if (store_st != CSI_ST_ERR) err_cnt <= 12'h000;
      else if (ms_tick) err_cnt <= err_cnt + 12'h001;
    end
  end

  // --------------------------------------------------------------------------
  // alarm outputs, boot erase, events
  // --------------------------------------------------------------------------
  logic boot_pending;
  logic alarm_any_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_out_first  <= 1'b0;
      alarm_out_second <= 1'b0;
      alarm_out_third  <= 1'b0;
      alarm_out_fourth <= 1'b0;
      boot_pending     <= 1'b1;
      erase_data       <= 1'b0;
    end else if (ce) begin
      // a new event in the clearing cycle keeps its output set
      alarm_out_first  <= alarm_event[0] | (alarm_out_first & ~alarm_clear_a);
      alarm_out_second <= alarm_event[1] | (alarm_out_second & ~alarm_clear_a);
      alarm_out_third  <= alarm_event[2] | (alarm_out_third & ~alarm_clear_b);
      alarm_out_fourth <= alarm_event[3] | (alarm_out_fourth & ~alarm_clear_b);
      boot_pending     <= 1'b0;
      if (boot_pending && reset_button) erase_data <= 1'b1;
      else if (erase_done) erase_data <= 1'b0;
    end
  end

  wire logic [5:0] ev = {boot_pending & reset_button,
                         (|ovf_q) & rms_strobe,
                         |alarm_event,
                         card_detect,
                         copy_error & (store_st == CSI_ST_COPY),
                         rms_strobe & (neg_seq > neg_thr) & ~phase_bad};
  wire logic [5:0] clr = wr_status ? w_data[5:0] : 6'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status      <= 6'h00;
      irq         <= 1'b0;
      alarm_any_q <= 1'b0;
    end else if (ce) begin
      status      <= ev | (status & ~clr);
      irq         <= |(status & mask);
      alarm_any_q <= alarm_out_first | alarm_out_second | alarm_out_third | alarm_out_fourth;
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  wire logic [31:0] state_word = {23'h000000, erase_data, alarm_any_q, led_storage, store_st, chase, phase_bad};
  wire logic        rd_hit     = (s_axi_araddr <= `CSI_OFF_STATE) & (s_axi_araddr[1:0] == 2'h0);
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_axi_araddr)
      `CSI_OFF_CTRL:    rd_mux = {31'h00000000, full_sel};
      `CSI_OFF_SERCFG:  rd_mux = {5'h00, ser_parity, ser_two_stop, ser_data_bits, ser_baud};
      `CSI_OFF_LIM_LO:  rd_mux = {16'h0000, lim_lo};
      `CSI_OFF_LIM_HI:  rd_mux = {16'h0000, lim_hi};
      `CSI_OFF_RANGE:   rd_mux = {15'h0000, range_cfg};
      `CSI_OFF_CHTYPE:  rd_mux = {24'h000000, is_current};
      `CSI_OFF_NEG_THR: rd_mux = {16'h0000, neg_thr};
      `CSI_OFF_STATUS:  rd_mux = {26'h0000000, status};
      `CSI_OFF_MASK:    rd_mux = {26'h0000000, mask};
      `CSI_OFF_STATE:   rd_mux = state_word;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : csi_top

// *** csi_top_properties.sv ***
// port assertions of the indicator block
`timescale 1ns/100ps
module csi_top_checker #(
  parameter int CYC_PER_MS = 2
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        rms_strobe,
  input wire logic [7:0]  adc_ovf,
  input wire logic [7:0]  sensor_ok,
  input wire logic        copy_done,
  input wire logic        copy_incomplete,
  input wire logic        copy_error,
  input wire logic [3:0]  alarm_event,
  input wire logic        alarm_clear_a,
  input wire logic        alarm_clear_b,
  input wire logic        reset_button,
  input wire logic        erase_done,
  input wire logic [7:0]  led_under_yellow,
  input wire logic [7:0]  led_ok_green,
  input wire logic [7:0]  led_ok_red,
  input wire logic [7:0]  led_over_yellow,
  input wire logic        led_storage,
  input wire logic        alarm_out_first,
  input wire logic        alarm_out_second,
  input wire logic        alarm_out_third,
  input wire logic        erase_data,
  input wire logic [19:0] ser_baud,
  input wire logic [3:0]  ser_data_bits,
  input wire logic        ser_two_stop,
  input wire logic [1:0]  ser_parity
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence steady_on;
    led_storage [*8];
  endsequence
  alarm_set_a: assert property (ce && alarm_event[0] |=> alarm_out_first) else $error("alarm not set");
  alarm_hold_a: assert property (ce && alarm_out_third && !alarm_clear_b |=> alarm_out_third) else $error("alarm lost");
  clear_pair_a: assert property (ce && alarm_clear_a && !alarm_event[1] |=> !alarm_out_second) else $error("no clear");
  // reset cycles in the window would see the flops still cleared
  ok_red_a: assert property ((aresetn && ce && $stable(sensor_ok)) [*3] |-> led_ok_red == ~sensor_ok) else $error("ok red");
  ovf_mask_a: assert property (ce && rms_strobe && adc_ovf[0] |-> ##2 !(led_under_yellow[0] || led_over_yellow[0] ||
    led_ok_green[0])) else $error("overflow shown wrong");
  ser_default_a: assert property ($rose(aresetn) |-> ser_baud == 20'h0e100 && ser_data_bits == 4'h8 && !ser_two_stop &&
    ser_parity == 2'h0) else $error("serial default");
  erase_boot_a: assert property (ce && $rose(aresetn) && reset_button |=> erase_data) else $error("no erase");
  erase_clr_a: assert property (ce && erase_done |=> !erase_data) else $error("erase stuck");
  copy_off_a: assert property (ce && copy_done && !copy_error && !copy_incomplete |-> ##[1:3] !led_storage)
    else $error("storage not off");
  hold_on_a: assert property (ce && copy_incomplete && !copy_error |-> ##3 steady_on) else $error("not steady");
  err_flash_a: assert property (ce && copy_error |-> ##[2:300] !led_storage) else $error("no fast flash");
endmodule : csi_top_checker
bind csi_top csi_top_checker #(.CYC_PER_MS(CYC_PER_MS)) csi_top_checker_inst (.*);

// *** test_csi_top.sv ***
// self-checking bench of the indicator block
`timescale 1ns/100ps
module test_csi_top;
  logic         aclk = '0, aresetn = '0, ce = '1, reset_button = '1, go = '0, card_detect = '0, rms_strobe, irq;
  logic         s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, led_storage, erase_data;
  logic         alarm_clear_a, alarm_clear_b, alarm_out_first, alarm_out_second, alarm_out_third, alarm_out_fourth;
  logic         ser_two_stop;
  logic [1:0]   s_axi_bresp, s_axi_rresp, ser_parity, r, clr = '0;
  logic [3:0]   s_axi_wstrb = 4'hf, ser_data_bits;
  logic [7:0]   s_axi_awaddr = '0, s_axi_araddr = '0, sensor_ok = '1, ovf = '0, adc_ovf, led_over_red;
  logic [7:0]   led_under_yellow, led_ok_green, led_ok_red, led_over_yellow;
  logic [8:0]   pv = '0;
  logic [15:0]  lvl = '0, neg_seq = '0;
  logic [19:0]  ser_baud;
  logic [31:0]  s_axi_wdata = '0, s_axi_rdata, d;
  logic [127:0] half_rms, full_rms;
  // level, overflow, sensors, then expected under, ok green, ok red, over yellow
  logic [63:0]  rows [6] = '{64'h4000_00ff_00ff_0000, 64'h0800_00ff_ff00_0000, 64'h9000_00ff_0000_00ff,
                           64'h4000_ffff_0000_0000, 64'h4000_0000_0000_ff00, 64'h0800_000f_ff00_f000};
  int           error_cnt = 0, checks = 0, cyc = 0;

  csi_top #(.CYC_PER_MS(2)) csi_top_inst (.copy_start(pv[0]), .copy_done(pv[1]), .copy_incomplete(pv[2]),
    .copy_error(pv[3]), .alarm_event(pv[7:4]), .erase_done(pv[8]), .*);
  csi_front_model csi_front_model_inst (.*);

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic pulse(input logic [8:0] v);
    pv <= v;
    @(posedge aclk);
    pv <= '0;
    @(posedge aclk);
  endtask : pulse
  task automatic strobe(input logic [15:0] l, input logic [7:0] o);
    lvl <= l;
    ovf <= o;
    go <= '1;
    @(posedge aclk);
    go <= '0;
    repeat (5) @(posedge aclk);
  endtask : strobe
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    s_axi_rready <= '0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axr
  task automatic finish_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    reset_button <= '0;
    @(posedge aclk);
    chk(32'(erase_data), 32'h1);
    chk(32'({ser_parity, ser_two_stop, ser_data_bits, ser_baud}), 32'h0080e100);
    pulse(9'h100);
    chk(32'(erase_data), 32'h0);
    axr(8'h04);
    chk(d, 32'h0080e100);
    axr(8'h40);
    chk(32'(r), 32'h2);
    axw(8'h08, 32'h1000);
    axw(8'h0c, 32'h8000);
    foreach (rows[i]) begin
      sensor_ok <= rows[i][39:32];
      strobe(rows[i][63:48], rows[i][47:40]);
      chk({led_under_yellow, led_ok_green, led_ok_red, led_over_yellow}, rows[i][31:0]);
    end
    axw(8'h00, 32'h1);
    strobe(16'h9000, 8'hf0);
    chk(32'(led_ok_green), 32'h0f);
    while (!led_over_red) @(posedge aclk);
    chk(32'(led_over_red), 32'hf0);
    axw(8'h14, 32'hff);
    axw(8'h10, 32'h1000);
    strobe(16'h0200, 8'h00);
    chk(32'(led_under_yellow), 32'hff);
    axw(8'h10, 32'h11000);
    strobe(16'h0200, 8'h00);
    chk(32'(led_under_yellow), 32'h0);
    pulse(9'h0f0);
    chk(32'({alarm_out_fourth, alarm_out_third, alarm_out_second, alarm_out_first}), 32'hf);
    clr <= 2'h1;
    repeat (3) @(posedge aclk);
    chk(32'({alarm_out_fourth, alarm_out_third, alarm_out_second, alarm_out_first}), 32'hc);
    clr <= 2'h2;
    repeat (3) @(posedge aclk);
    chk(32'({alarm_out_fourth, alarm_out_third, alarm_out_second, alarm_out_first}), 32'h0);
    chk(32'(irq), 32'h0);
    axw(8'h20, 32'h2);
    pulse(9'h001);
    pulse(9'h004);
    repeat (10) @(posedge aclk);
    chk(32'(led_storage), 32'h1);
    // restart from hold, where the LED is steady
    pulse(9'h001);
    pulse(9'h008);
    repeat (6300) @(posedge aclk);
    chk(32'(led_storage), 32'h1);
    chk(32'(irq), 32'h1);
    axw(8'h1c, 32'h2);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    pulse(9'h001);
    pulse(9'h002);
    repeat (3) @(posedge aclk);
    chk(32'(led_storage), 32'h0);
    card_detect <= '1;
    axr(8'h24);
    card_detect <= '0;
    chk(d & 32'h38, 32'h8);
    finish_test();
  end
endmodule : test_csi_top
